/* File: tas_pkg.sv */
// package for the trigger/arm sequencer: offsets, fields, resets, timing
package tas_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] OFS_CTRL     = 8'h00; // commands, pulse on write
   localparam logic [7:0] OFS_ARMCFG   = 8'h04; // arm event, bypass, line
   localparam logic [7:0] OFS_TRGCFG   = 8'h08; // trigger source, bypass
   localparam logic [7:0] OFS_ARMCNT   = 8'h0C; // arm count, 0 = infinite
   localparam logic [7:0] OFS_TRGCNT   = 8'h10; // trigger count
   localparam logic [7:0] OFS_TDELAY   = 8'h14; // trigger delay, us
   localparam logic [7:0] OFS_DDELAY   = 8'h18; // delay action, us
   localparam logic [7:0] OFS_SOAK     = 8'h1C; // soak time, us
   localparam logic [7:0] OFS_TIMER    = 8'h20; // arm timer interval, us
   localparam logic [7:0] OFS_MEASCFG  = 8'h24; // filter, conversions, mode
   localparam logic [7:0] OFS_STATUS   = 8'h28; // read-only state

   // control register bit positions (write one to fire, except the level bits)
   localparam int CTL_INIT    = 0;  // initiate
   localparam int CTL_READ    = 1;  // read query
   localparam int CTL_MEAS    = 2;  // measure query
   localparam int CTL_ABORT   = 3;  // abort
   localparam int CTL_DCL     = 4;  // device clear
   localparam int CTL_SDC     = 5;  // selected device clear
   localparam int CTL_IFC     = 6;  // interface clear
   localparam int CTL_BUSTRG  = 7;  // group execute / common trigger
   localparam int CTL_OUTON   = 8;  // output on
   localparam int CTL_OUTOFF  = 9;  // output off
   localparam int CTL_OTHER   = 10; // any other command (queued)
   localparam int CTL_LOCAL   = 11; // 1 = local front panel mode (level)
   localparam int CTL_AUTOOFF = 12; // auto output-off enable (level)

   // field positions in the config registers
   localparam int ARM_SRC_LSB = 0;  // 3 bits
   localparam int ARM_BYP_BIT = 4;  // bypass once
   localparam int ARM_LIN_LSB = 8;  // 2 bits line
   localparam int TRG_SRC_BIT = 0;  // 0 immediate, 1 hardware line
   localparam int TRG_BYP_BIT = 4;
   localparam int TRG_LIN_LSB = 8;
   localparam int TRG_IN_LSB  = 12; // source, delay, measure enables
   localparam int MC_FILT_BIT = 0;  // repeat filter on
   localparam int MC_MULT_BIT = 1;  // multiple cycle mode
   localparam int MC_AUTO_BIT = 2;  // automatic delay
   localparam int MC_CONV_LSB = 8;  // 8 bits conversion count

   // reset values
   localparam logic [31:0] RST_ARMCNT = 32'h0000_0001;
   localparam logic [31:0] RST_TRGCNT = 32'h0000_0001;
   localparam logic [31:0] RST_DDELAY = 32'h0000_03E8; // 1 ms in us
   localparam logic [31:0] RST_TRGCFG = 32'h0000_1000; // source det on
   localparam logic [31:0] RST_ZERO   = 32'h0000_0000;

   // timing: microsecond tick from a 40 MHz clock
   localparam int CLK_MHZ      = 40;
   localparam int TICK_US      = 1;
   localparam int TICK_CYC     = CLK_MHZ * TICK_US;
   localparam int BUF_SIZE     = 2500;  // reading buffer depth
   localparam int AUTO_DLY_US  = 1000;  // nominal automatic delay

   // arm event selections
   typedef enum logic [2:0] {
      ARM_IMM, ARM_BUS, ARM_TIMER, ARM_MANUAL, ARM_HWLINE,
      ARM_START_LOW, ARM_START_HIGH, ARM_START_EITHER
   } tas_arm_ev_t;

   // sequencer states
   typedef enum logic [3:0] {
      ST_IDLE, ST_ARM, ST_TDLY, ST_SRC_DET, ST_SRC_ACT, ST_DLY_DET,
      ST_DLY_ACT, ST_MEAS_DET, ST_MEAS_ACT, ST_NEXT
   } tas_state_t;

   // measurement handshake carrier
   typedef struct packed {
      logic        conv_req;    // request conversions while high
      logic        reading_vld; // one finished reading
   } tas_meas_t;

endpackage

/* File: tas_sequencer.sv */
// trigger and arm sequencer with AHB-Lite register slave
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - idle takes no readings; initiate/read/measure leave
// - queue ordinary commands while sequence runs
// - auto-off: output on per cycle, off after
// - without auto-off, output stays on at idle
// - clears and abort return to idle anytime
// - stall at active detectors; bypass may skip
// - arm bypass only hardware-line/start-test, once
// - immediate arm event passes at once
// - bus arm event waits for bus trigger
// - timer: first pass immediate, resets in idle
// - manual key honoured only in local mode
// - hardware-line arm waits selected input trigger
// - start-test low/high/either pulse satisfies arm
// - three trigger detectors; source bypass hardware-line
// - immediate trigger source passes all detectors
// - disabled hardware-line detector never stalls
// - each enabled detector consumes its own trigger
// - trigger delay before each source action
// - delay action time or automatic nominal delay
// - soak replaces first delay in multiple-cycle mode
// - repeat filter takes N conversions per reading
// - trigger count times arm count, BUF_SIZE not enforced
// - defaults run one cycle then go idle
module tas_sequencer #(
   parameter int LINES = 4            // hardware trigger input lines
) (
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire logic                    hsel,
   input  wire logic [7:0]              haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   input  wire logic [LINES-1:0]        hw_trig_n,   // falling-edge lines
   input  wire logic                    start_of_test_line,
   input  wire logic                    trig_key,    // front panel key
   output logic                         output_on,   // source output
   output logic                         source_act,  // source action pulse
   output tas_pkg::tas_meas_t           meas,        // conversion control
   input  wire logic                    conv_done,   // conversion finished
   output logic                         seq_busy     // not idle
);
   import tas_pkg::*;

   // register copies
   logic [31:0] armcfg_ff, trgcfg_ff, armcnt_ff, trgcnt_ff;
   logic [31:0] tdelay_ff, ddelay_ff, soak_ff, timer_ff, meascfg_ff;
   logic        local_ff, autooff_ff;   // level controls
   logic        pending_ff;             // queued ordinary command
   tas_state_t  state_ff;

   // bus address phase capture
   logic        wr_ff;
   logic [7:0]  addr_ff;
   logic        wr_go;
   assign wr_go = hsel & hready & htrans[1] & hwrite;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_ff   <= 1'b0;
         addr_ff <= 8'h00;
      end else begin
         wr_ff   <= wr_go;
         addr_ff <= haddr;
      end
   end

   // zero wait state, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // command pulses out of the control register
   logic [31:0] cmd;
   assign cmd = (wr_ff && addr_ff == OFS_CTRL) ? hwdata : 32'h0000_0000;

   logic do_clear, do_init, busy;
   assign busy     = (state_ff != ST_IDLE);
   assign do_clear = cmd[CTL_ABORT] | cmd[CTL_DCL] | cmd[CTL_SDC];
   assign do_init  = cmd[CTL_INIT] | cmd[CTL_READ] | cmd[CTL_MEAS];

   // configuration registers, writes held off while busy
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         armcfg_ff  <= RST_ZERO;
         trgcfg_ff  <= RST_TRGCFG;
         armcnt_ff  <= RST_ARMCNT;
         trgcnt_ff  <= RST_TRGCNT;
         tdelay_ff  <= RST_ZERO;
         ddelay_ff  <= RST_DDELAY;
         soak_ff    <= RST_ZERO;
         timer_ff   <= RST_ZERO;
         meascfg_ff <= RST_ZERO;
      end else if (wr_ff && !busy) begin
         case (addr_ff)
            OFS_ARMCFG:  armcfg_ff  <= hwdata;
            OFS_TRGCFG:  trgcfg_ff  <= hwdata;
            OFS_ARMCNT:  armcnt_ff  <= hwdata;
            OFS_TRGCNT:  trgcnt_ff  <= hwdata;
            OFS_TDELAY:  tdelay_ff  <= hwdata;
            OFS_DDELAY:  ddelay_ff  <= hwdata;
            OFS_SOAK:    soak_ff    <= hwdata;
            OFS_TIMER:   timer_ff   <= hwdata;
            OFS_MEASCFG: meascfg_ff <= hwdata;
            default: ;
         endcase
      end
   end

   // level controls and the queued-command flag
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         local_ff   <= 1'b0;
         autooff_ff <= 1'b0;
         pending_ff <= 1'b0;
      end else begin
         if (wr_ff && addr_ff == OFS_CTRL && !busy) begin
            local_ff   <= hwdata[CTL_LOCAL];
            autooff_ff <= hwdata[CTL_AUTOOFF];
         end
         // ordinary commands wait; clears cancel them
         if (cmd[CTL_OTHER] && busy)
            pending_ff <= 1'b1;
         else if (do_clear || cmd[CTL_IFC] || !busy)
            pending_ff <= 1'b0;
      end
   end

   // two-stage synchronisers on pins
   logic [LINES-1:0] ln_s1, ln_s2, ln_s3;
   logic [2:0]       sot_s;
   logic [1:0]       key_s;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ln_s1 <= '1;
         ln_s2 <= '1;
         ln_s3 <= '1;
         sot_s <= 3'h7; // handler line rests high, no false edge
         key_s <= 2'h0;
      end else begin
         ln_s1 <= hw_trig_n;
         ln_s2 <= ln_s1;
         ln_s3 <= ln_s2;
         sot_s <= {sot_s[1:0], start_of_test_line};
         key_s <= {key_s[0], trig_key};
      end
   end
   logic key_d;
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         key_d <= 1'b0;
      else
         key_d <= key_s[1];
   end

   // falling edge of a selected line
   function automatic logic line_fall(input logic [1:0] sel);
      logic [LINES-1:0] f;
      f = ln_s3 & ~ln_s2;
      return f[sel];
   endfunction

   logic sot_rise, sot_fall, key_press;
   assign sot_rise  = sot_s[1] & ~sot_s[2];
   assign sot_fall  = ~sot_s[1] & sot_s[2];
   assign key_press = key_s[1] & ~key_d;

   // decoded fields
   tas_arm_ev_t arm_ev;
   logic        arm_byp, trg_hw, trg_byp, filt_on, mult_on, auto_dly;
   logic [2:0]  trg_in;
   logic [7:0]  conv_n;
   assign arm_ev   = tas_arm_ev_t'(armcfg_ff[ARM_SRC_LSB +: 3]);
   assign arm_byp  = armcfg_ff[ARM_BYP_BIT];
   assign trg_hw   = trgcfg_ff[TRG_SRC_BIT];
   assign trg_byp  = trgcfg_ff[TRG_BYP_BIT];
   assign trg_in   = trgcfg_ff[TRG_IN_LSB +: 3];
   assign filt_on  = meascfg_ff[MC_FILT_BIT];
   assign mult_on  = meascfg_ff[MC_MULT_BIT];
   assign auto_dly = meascfg_ff[MC_AUTO_BIT];
   assign conv_n   = meascfg_ff[MC_CONV_LSB +: 8];

   // microsecond tick
   logic [5:0] pre_ff;
   logic       tick;
   assign tick = (pre_ff == 6'(TICK_CYC - 1));
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         pre_ff <= 6'h00;
      else
         pre_ff <= tick ? 6'h00 : pre_ff + 6'h01;
   end

   // arm timer: free runs in every non-idle state, cleared in idle
   logic [31:0] atim_ff;
   logic        atim_hit_ff, first_pass_ff;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         atim_ff     <= 32'h0000_0000;
         atim_hit_ff <= 1'b0;
      end else if (!busy) begin
         atim_ff     <= 32'h0000_0000;
         atim_hit_ff <= 1'b0;
      end else begin
         if (tick)
            atim_ff <= (atim_ff + 32'h1 >= timer_ff) ? 32'h0 : atim_ff + 32'h1;
         if (tick && atim_ff + 32'h1 >= timer_ff)
            atim_hit_ff <= 1'b1;
         else if (state_ff == ST_ARM)
            atim_hit_ff <= 1'b0;
      end
   end

   // arm detector satisfied
   logic arm_ok;
   always_comb begin
      arm_ok = 1'b0;
      case (arm_ev)
         ARM_IMM:          arm_ok = 1'b1;
         ARM_BUS:          arm_ok = cmd[CTL_BUSTRG];
         ARM_TIMER:        arm_ok = first_pass_ff | atim_hit_ff;
         ARM_MANUAL:       arm_ok = key_press & local_ff;
         ARM_HWLINE:       arm_ok = line_fall(armcfg_ff[ARM_LIN_LSB +: 2]);
         ARM_START_LOW:    arm_ok = sot_fall;
         ARM_START_HIGH:   arm_ok = sot_rise;
         ARM_START_EITHER: arm_ok = sot_rise | sot_fall;
         default:          arm_ok = 1'b0;
      endcase
   end

   // arm bypass valid only for line or start-test events
   logic arm_byp_ok;
   assign arm_byp_ok = arm_byp & (arm_ev == ARM_HWLINE ||
                       arm_ev == ARM_START_LOW || arm_ev == ARM_START_HIGH ||
                       arm_ev == ARM_START_EITHER);

   // trigger detector satisfied: own edge each, none if disabled
   logic trg_edge;
   assign trg_edge = line_fall(trgcfg_ff[TRG_LIN_LSB +: 2]);
   function automatic logic det_ok(input logic en);
      return !trg_hw || !en || trg_edge;
   endfunction

   // shared countdown for delays and conversions
   logic [31:0] wait_ff, acnt_ff, tcnt_ff;
   logic        first_sdm_ff;
   tas_state_t  nxt_state;
   logic [31:0] dly_load;
   always_comb begin
      if (mult_on && first_sdm_ff)
         dly_load = soak_ff;
      else if (auto_dly)
         dly_load = 32'(AUTO_DLY_US);
      else
         dly_load = ddelay_ff;
   end

   // next state: ordered pass through the trigger layer
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:     if (do_init) nxt_state = ST_ARM;
         ST_ARM:      if (arm_ok || (arm_byp_ok && first_pass_ff))
                         nxt_state = ST_TDLY;
         ST_TDLY:     if (wait_ff == 32'h0)
                         nxt_state = ST_SRC_DET;
         ST_SRC_DET:  if ((trg_hw && trg_byp && first_sdm_ff) ||
                          det_ok(trg_in[0]))
                         nxt_state = ST_SRC_ACT;
         ST_SRC_ACT:  nxt_state = ST_DLY_DET;
         ST_DLY_DET:  if (det_ok(trg_in[1])) nxt_state = ST_DLY_ACT;
         ST_DLY_ACT:  if (wait_ff == 32'h0) nxt_state = ST_MEAS_DET;
         ST_MEAS_DET: if (det_ok(trg_in[2])) nxt_state = ST_MEAS_ACT;
         ST_MEAS_ACT: if (conv_done && wait_ff <= 32'h1)
                         nxt_state = ST_NEXT;
         ST_NEXT: begin
            if (tcnt_ff > 32'h1)
               nxt_state = ST_TDLY;
            else if (armcnt_ff == 32'h0 || acnt_ff > 32'h1)
               nxt_state = ST_ARM;
            else
               nxt_state = ST_IDLE;
         end
         default:     nxt_state = ST_IDLE;
      endcase
      if (do_clear || cmd[CTL_IFC]) nxt_state = ST_IDLE;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   // counters and waits
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wait_ff       <= 32'h0;
         acnt_ff       <= 32'h0;
         tcnt_ff       <= 32'h0;
         first_pass_ff <= 1'b1;
         first_sdm_ff  <= 1'b1;
      end else begin
         if (state_ff == ST_IDLE) begin
            acnt_ff       <= armcnt_ff;
            first_pass_ff <= 1'b1;
            first_sdm_ff  <= 1'b1;
         end
         if (state_ff == ST_ARM && nxt_state == ST_TDLY) begin
            tcnt_ff       <= trgcnt_ff;
            first_pass_ff <= 1'b0;
            wait_ff       <= tdelay_ff;
         end
         if ((state_ff == ST_TDLY || state_ff == ST_DLY_ACT) &&
             tick && wait_ff != 32'h0)
            wait_ff <= wait_ff - 32'h1;
         if (state_ff == ST_SRC_ACT)
            wait_ff <= dly_load;
         if (state_ff == ST_MEAS_DET)
            wait_ff <= filt_on ? {24'h0, conv_n} : 32'h1;
         if (state_ff == ST_MEAS_ACT && conv_done && wait_ff != 32'h0)
            wait_ff <= wait_ff - 32'h1;
         if (state_ff == ST_NEXT) begin
            first_sdm_ff <= 1'b0;
            if (tcnt_ff > 32'h1) begin
               tcnt_ff <= tcnt_ff - 32'h1;
               wait_ff <= tdelay_ff;
            end else if (acnt_ff != 32'h0)
               acnt_ff <= acnt_ff - 32'h1;
         end
      end
   end

   // source output control
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         output_on <= 1'b0;
      else if (cmd[CTL_OUTOFF])
         output_on <= 1'b0;
      else if (cmd[CTL_OUTON] || cmd[CTL_MEAS])
         output_on <= 1'b1;
      else if (autooff_ff && state_ff == ST_SRC_ACT)
         output_on <= 1'b1;
      else if (autooff_ff && state_ff == ST_NEXT)
         output_on <= 1'b0;
   end

   // registered action outputs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         source_act <= 1'b0;
         meas       <= '0;
         seq_busy   <= 1'b0;
      end else begin
         source_act       <= (state_ff == ST_SRC_ACT);
         meas.conv_req    <= (state_ff == ST_MEAS_ACT);
         meas.reading_vld <= (nxt_state == ST_NEXT &&
                              state_ff == ST_MEAS_ACT);
         seq_busy         <= (nxt_state != ST_IDLE);
      end
   end

   // read data, registered in the data phase
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         hrdata <= 32'h0;
      else if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr)
            OFS_ARMCFG:  hrdata <= armcfg_ff;
            OFS_TRGCFG:  hrdata <= trgcfg_ff;
            OFS_ARMCNT:  hrdata <= armcnt_ff;
            OFS_TRGCNT:  hrdata <= trgcnt_ff;
            OFS_TDELAY:  hrdata <= tdelay_ff;
            OFS_DDELAY:  hrdata <= ddelay_ff;
            OFS_SOAK:    hrdata <= soak_ff;
            OFS_TIMER:   hrdata <= timer_ff;
            OFS_MEASCFG: hrdata <= meascfg_ff;
            OFS_STATUS:  hrdata <= {24'h0, pending_ff, output_on,
                                    busy, 1'b0, 4'(state_ff)};
            default:     hrdata <= 32'h0;
         endcase
      end
   end

endmodule

/* File: tas_sequencer_assertions.sv */
// port-level checks for the trigger and arm sequencer
`timescale 1ns/1ps
module tas_sequencer_chk
   import tas_pkg::*;
#(
   parameter int LINES = 4 // trigger input lines
) (
   input wire logic         clock,
   input wire logic         rst,
   input wire logic         hsel,
   input wire logic [7:0]   haddr,
   input wire logic [1:0]   htrans,
   input wire logic         hwrite,
   input wire logic [31:0]  hwdata,
   input wire logic         hready,
   input wire logic         hreadyout,
   input wire logic         hresp,
   input wire logic         output_on,
   input wire logic         source_act,
   input wire tas_meas_t    meas,
   input wire logic         seq_busy
);
   import tas_pkg::*;
   logic ctl_ff; // control register in its data phase
   logic src_ff; // source action seen since last conversion burst
   // flag the data phase of a control write
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctl_ff <= 1'b0;
      end else begin
         ctl_ff <= hsel && hready && htrans[1] && hwrite
                   && haddr == OFS_CTRL;
      end
   end
   // remembers a source action until conversions start
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         src_ff <= 1'b0;
      end else begin
         src_ff <= seq_busy && (source_act || (src_ff && !meas.conv_req));
      end
   end
   a_bus_okay: assert property (@(posedge clock) disable iff (rst)
      hreadyout && !hresp) else $error("bus stalled or error response");
   a_idle_no_conv: assert property (@(posedge clock) disable iff (rst)
      !seq_busy |-> !meas.conv_req && !source_act)
      else $error("activity while idle");
   a_init_leaves: assert property (@(posedge clock) disable iff (rst)
      ctl_ff && hwdata[CTL_INIT] && !seq_busy && !hwdata[CTL_ABORT]
      && !hwdata[CTL_DCL] && !hwdata[CTL_SDC] && !hwdata[CTL_IFC]
      |-> ##[1:3] seq_busy) else $error("initiate did not leave idle");
   a_abort_idle: assert property (@(posedge clock) disable iff (rst)
      ctl_ff && (hwdata[CTL_ABORT] || hwdata[CTL_DCL] || hwdata[CTL_SDC]
      || hwdata[CTL_IFC])
      |-> ##[1:4] !seq_busy) else $error("abort did not reach idle");
   a_src_pulse: assert property (@(posedge clock) disable iff (rst)
      source_act |=> !source_act) else $error("source pulse too long");
   a_conv_order: assert property (@(posedge clock) disable iff (rst)
      $rose(meas.conv_req) |-> src_ff)
      else $error("measure before source action");
   a_vld_pulse: assert property (@(posedge clock) disable iff (rst)
      meas.reading_vld |=> !meas.reading_vld)
      else $error("reading strobe too long");
   a_idle_out_hold: assert property (@(posedge clock) disable iff (rst)
      !seq_busy && !ctl_ff && !$past(seq_busy) |=> $stable(output_on))
      else $error("output changed in idle");
endmodule
bind tas_sequencer tas_sequencer_chk #(.LINES(LINES)) chk_i (
   .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .output_on(output_on),
   .source_act(source_act), .meas(meas), .seq_busy(seq_busy));

/* File: tas_conv_partner.sv */
// converter, trigger-line instruments and handler beside the sequencer
`timescale 1ns/1ps
module tas_conv_partner (
   input wire logic             clock,
   input wire logic             rst,
   input wire tas_pkg::tas_meas_t meas,
   output logic                 conv_done,
   output logic [3:0]           hw_trig_n,
   output logic                 start_of_test_line
);
   import tas_pkg::*;
   int lat = 3;       // conversion time in cycles, less one; set by the bench
   int cnt_ff;        // cycles into the current conversion
   // one done pulse every lat+1 cycles while conversions are asked for
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_ff    <= 0;
         conv_done <= 1'b0;
      end else if (meas.conv_req && cnt_ff >= lat) begin
         cnt_ff    <= 0;
         conv_done <= 1'b1;
      end else begin
         cnt_ff    <= meas.conv_req ? cnt_ff + 1 : 0;
         conv_done <= 1'b0;
      end
   end
   // lines rest high (pulled up); handler line starts high
   initial begin
      hw_trig_n          = 4'hF;
      start_of_test_line = 1'b1;
   end
   // falling-edge pulse on one line, long enough to pass sync
   task automatic line_pulse(input int idx);
      @(posedge clock);
      hw_trig_n[idx] <= 1'b0;
      repeat (4) @(posedge clock);
      hw_trig_n[idx] <= 1'b1;
   endtask
   // one handler pulse of level lvl, idle at the opposite level
   task automatic sot_pulse(input logic lvl);
      @(posedge clock);
      start_of_test_line <= !lvl;
      repeat (8) @(posedge clock);
      start_of_test_line <= lvl;
      repeat (4) @(posedge clock);
      start_of_test_line <= !lvl;
   endtask
endmodule

/* File: tb_top.sv */
// register-level test sequences for the trigger and arm sequencer
`timescale 1ns/1ps
module tb_top;
   import tas_pkg::*;
   logic        clock = 1'b0;     // 40 MHz
   logic        rst = 1'b1;       // async, held at start
   logic        hsel = 1'b0;      // bus request
   logic [7:0]  haddr = 8'h00;
   logic [2:0]  hsize = 3'b000;   // transfer size
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        trig_key = 1'b0;  // front panel key
   logic [31:0] hrdata, rv, lvl = 32'h0; // lvl: level bits of control
   logic        hreadyout, hresp, output_on, source_act, seq_busy;
   logic        conv_done, start_of_test_line;
   logic [3:0]  hw_trig_n;
   tas_meas_t   meas;
   int errors = 0, checks = 0, n_src, n_rd, n_cv, on_seen;
   tas_sequencer #(.LINES(4)) tas_sequencer_i (
      .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .hw_trig_n(hw_trig_n),
      .start_of_test_line(start_of_test_line), .trig_key(trig_key),
      .output_on(output_on), .source_act(source_act), .meas(meas),
      .conv_done(conv_done), .seq_busy(seq_busy));
   tas_conv_partner tas_conv_partner_i (
      .clock(clock), .rst(rst), .meas(meas), .conv_done(conv_done),
      .hw_trig_n(hw_trig_n), .start_of_test_line(start_of_test_line));
   initial begin
      forever #12.5 clock = ~clock;
   end
   // tally outputs so runs can be judged afterwards
   always @(posedge clock) begin
      if (source_act === 1'b1) n_src++;
      if (meas.reading_vld === 1'b1) n_rd++;
      if (conv_done === 1'b1) n_cv++;
      if (output_on === 1'b1) on_seen = 1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one single-word transfer; hold each phase until ready
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
      hsize <= 3'b010; // whole word only
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   task automatic ctl(input logic [31:0] b);
      n_src = 0; n_rd = 0; n_cv = 0; on_seen = 0;
      xfer(OFS_CTRL, 1'b1, b | lvl);
   endtask
   task automatic wait_idle;
      repeat (4) @(posedge clock);
      while (seq_busy !== 1'b0) @(posedge clock);
   endtask
   task automatic stalled; // run must still wait, nothing sourced
      repeat (40) @(posedge clock);
      chk({31'h0, seq_busy}, 32'h1);
      chk(n_src, 0);
   endtask
   task automatic end_sim;
      if (errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clock);
      errors++;
      end_sim();
   end
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      xfer(OFS_ARMCNT, 0, 0); chk(rv, RST_ARMCNT);
      xfer(OFS_TRGCNT, 0, 0); chk(rv, RST_TRGCNT);
      xfer(OFS_DDELAY, 0, 0); chk(rv, RST_DDELAY);
      xfer(OFS_TRGCFG, 0, 0); chk(rv, RST_TRGCFG);
      xfer(8'h30, 0, 0); chk(rv, 32'h0); // unmapped reads zero
      xfer(OFS_DDELAY, 1, 32'h2);
      ctl(32'h1 << CTL_OUTON); wait_idle; chk(n_src, 0);
      ctl(32'h1 << CTL_INIT); wait_idle;
      chk(n_src + n_rd, 2); chk({31'h0, output_on}, 32'h1);
      xfer(OFS_TRGCNT, 1, 32'h3); ctl(1 << CTL_INIT); wait_idle;
      chk(n_src, 3); xfer(OFS_TRGCNT, 1, 32'h1);
      xfer(OFS_MEASCFG, 1, 32'h0401); ctl(1 << CTL_INIT); wait_idle;
      chk(n_rd * 8 + n_cv, 12); xfer(OFS_MEASCFG, 1, 0);
      xfer(OFS_ARMCFG, 1, 32'h1); ctl(1 << CTL_INIT); stalled;
      ctl(1 << CTL_OTHER); xfer(OFS_STATUS, 0, 0);
      chk(rv[7], 1);
      ctl(1 << CTL_BUSTRG); wait_idle; chk(n_src, 1);
      for (int i = CTL_ABORT; i <= CTL_IFC; i++) begin
         ctl(1 << CTL_INIT); repeat (10) @(posedge clock);
         ctl(1 << i); repeat (6) @(posedge clock);
         chk(n_src + seq_busy, 0);
      end
      xfer(OFS_TIMER, 1, 32'h5); xfer(OFS_ARMCNT, 1, 32'h2);
      xfer(OFS_ARMCFG, 1, 32'h2); ctl(1 << CTL_INIT);
      repeat (150) @(posedge clock); chk(n_src, 1);
      wait_idle; chk(n_src, 2); xfer(OFS_ARMCNT, 1, 32'h1);
      xfer(OFS_ARMCFG, 1, 32'h3); ctl(1 << CTL_INIT);
      trig_key <= 1'b1; stalled; trig_key <= 1'b0;
      ctl(1 << CTL_ABORT); wait_idle; lvl = 1 << CTL_LOCAL;
      ctl(1 << CTL_INIT); repeat (8) @(posedge clock);
      trig_key <= 1'b1; wait_idle; trig_key <= 1'b0;
      chk(n_src, 1);
      xfer(OFS_ARMCFG, 1, 32'h204); ctl(1 << CTL_INIT);
      tas_conv_partner_i.line_pulse(1); stalled;
      tas_conv_partner_i.line_pulse(2); wait_idle; chk(n_src, 1);
      for (int ev = 5; ev < 8; ev++) begin
         xfer(OFS_ARMCFG, 1, ev); ctl(1 << CTL_INIT);
         tas_conv_partner_i.sot_pulse(ev == 6);
         wait_idle; chk(n_src, 1);
      end
      xfer(OFS_ARMCFG, 1, 0); xfer(OFS_TRGCFG, 1, 32'h6001);
      ctl(1 << CTL_INIT); repeat (200) @(posedge clock);
      chk(n_src * 8 + n_rd, 8);
      tas_conv_partner_i.line_pulse(0); repeat (200) @(posedge clock);
      chk(n_rd, 0);
      tas_conv_partner_i.line_pulse(0); wait_idle; chk(n_rd, 1);
      xfer(OFS_TRGCFG, 1, RST_TRGCFG); ctl(1 << CTL_OUTOFF);
      ctl(1 << CTL_MEAS); wait_idle;
      chk({31'h0, output_on}, 32'h1); lvl = 1 << CTL_AUTOOFF;
      tas_conv_partner_i.lat = 30; ctl(1 << CTL_OUTOFF); wait_idle;
      ctl(1 << CTL_INIT); wait_idle;
      chk(on_seen * 2 + output_on, 2);
      end_sim();
   end
endmodule
